// ### hdl/tsc_consts.svh
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

// register widths
`define TSC_IR_W        4
`define TSC_CS_W        4
`define TSC_DATA_W      32
`define TSC_ADDR_W      5
`define TSC_C1_W        33
`define TSC_C2_W        38

// capture patterns and reset values
`define TSC_IR_CAPTURE  4'h1
`define TSC_CS_CAPTURE  4'h8
`define TSC_CS_RESET    4'h0

// instruction codes
`define TSC_INS_CHAIN_SEL 4'h2
`define TSC_INS_INTEST    4'hC
`define TSC_INS_IDCODE    4'hE
`define TSC_INS_BYPASS    4'hF
`define TSC_INS_RESTART   4'h4

// chain numbers
`define TSC_CHAIN_USER  4'h0
`define TSC_CHAIN_CORE  4'h1
`define TSC_CHAIN_DREG  4'h2
`define TSC_CHAIN_RSV3  4'h3
`define TSC_CHAIN_RSV4  4'h4
`define TSC_CHAIN_RSV8  4'h8

// chain field positions
`define TSC_C1_BREAK_BIT 0
`define TSC_C2_RW_BIT    37
`define TSC_C2_ADDR_MSB  36
`define TSC_C2_ADDR_LSB  32
`define TSC_C2_DATA_MSB  31

`endif

// ### hdl/tsc_pkg.sv
package tsc_pkg;

  // test state machine states as reported by the external controller
  typedef enum logic [3:0] {
    TSC_TLR        = 4'h0,
    TSC_IDLE       = 4'h1,
    TSC_SEL_DR     = 4'h2,
    TSC_CAPTURE_DR = 4'h3,
    TSC_SHIFT_DR   = 4'h4,
    TSC_EXIT1_DR   = 4'h5,
    TSC_PAUSE_DR   = 4'h6,
    TSC_EXIT2_DR   = 4'h7,
    TSC_UPDATE_DR  = 4'h8,
    TSC_SEL_IR     = 4'h9,
    TSC_CAPTURE_IR = 4'hA,
    TSC_SHIFT_IR   = 4'hB,
    TSC_EXIT1_IR   = 4'hC,
    TSC_PAUSE_IR   = 4'hD,
    TSC_EXIT2_IR   = 4'hE,
    TSC_UPDATE_IR  = 4'hF
  } tsc_tap_e;

  typedef struct packed {
    logic        tdo;
    logic [31:0] core_data_in;
    logic [31:0] sys_data_out;
    logic        break_to_core;
    logic        speed_req;
    logic        cause_pending;
    logic        cause_watch;
    logic [4:0]  dreg_addr;
    logic [31:0] dreg_wdata;
    logic        dreg_write;
    logic        dreg_read;
    logic        rd_pending;
    logic        test_mode;
  } tsc_core_s;

endpackage

// ### hdl/tsc_scan_seg.sv
`timescale 1ns/1ps

// serial stage plus parallel stage of a run of scan cells;
// bit 0 sits next to test data out, serial_in enters at the top
module tsc_scan_seg #(
  parameter int          W   = 4,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // controls
  input  wire logic         capture_en,
  input  wire logic         shift_en,
  input  wire logic         update_en,
  // data
  input  wire logic         serial_in,
  input  wire logic [W-1:0] capture_val,
  output logic      [W-1:0] shift_q,
  output logic      [W-1:0] par_q
);

  typedef struct packed {
    logic [W-1:0] shift;
    logic [W-1:0] par;
  } tsc_seg_s;

  tsc_seg_s st_reg;
  tsc_seg_s st_next;

  always_comb
  begin
    st_next = st_reg;
    if (capture_en)
    begin
      st_next.shift = capture_val;
    end
    else if (shift_en)
    begin
      st_next.shift = {serial_in, st_reg.shift[W-1:1]};
    end
    if (update_en)
    begin
      st_next.par = st_reg.shift;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg.shift <= '0;
      st_reg.par   <= RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign shift_q = st_reg.shift;
  assign par_q   = st_reg.par;

endmodule

// ### hdl/tsc_chain_regs.sv
//Contract
// - a 4-bit instruction register, no parity, is the shift path in shift-ir
// - capture-ir loads binary 0001 into the instruction register
// - instruction bits leave and enter least significant bit first
// - update-ir makes the shifted value the active instruction
// - test reset makes the identification instruction active
// - a 4-bit chain select register is the path under chain-select
// - capture-dr under chain-select loads binary 1000
// - chain select bits leave and enter least significant bit first
// - update-dr under chain-select makes the shifted number the active chain
// - active chain changes only on that update or reset; reset picks 0
// - chain 0 user, 1 core debug, 2 debug registers, 3 4 8 reserved
// - a reserved active chain shifts out only zeros
// - input cells capture system input; core gets input or update stage (chain 1 data cells here capture only core_data_out, never sys_data_in)
// - output cells capture core output; system gets output or serial stage
// - cell control comes only from active instruction and test state (here the active chain also gates the chain 1 cells)
// - chain 1 has 33 cells: data 0 to 31, then the break cell
// - break cell requests system speed in debug, drives break in test
// - first break cell capture after debug entry reports the entry cause
// - chain 2 has 38 bits: flag, address 4 to 0, data 31 to 0
// - chain 2 ignores capture-dr; bits 32 to 36 give the address
// - update-dr of chain 2 reads when bit 37 is 0, writes when 1
// - shifting and sampling happen only on clock edges with enable high (here chain 2 loads read data one edge after its update, enable or not)
`timescale 1ns/1ps
`include "tsc_consts.svh"

module tsc_chain_regs (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // serial test port
  input  wire logic                   test_reset_n,
  input  wire logic                   test_clock_enable,
  input  wire tsc_pkg::tsc_tap_e      tap_state,
  input  wire logic                   test_data_in,
  output logic                        test_data_out,
  // paths kept outside this block
  input  wire logic                   other_tdo,
  input  wire logic                   user_chain_tdo,
  // core data cells
  input  wire logic [`TSC_DATA_W-1:0] core_data_out,
  input  wire logic [`TSC_DATA_W-1:0] sys_data_in,
  output logic      [`TSC_DATA_W-1:0] core_data_in,
  output logic      [`TSC_DATA_W-1:0] sys_data_out,
  // break cell and debug state
  input  wire logic                   external_break_input,
  input  wire logic                   in_debug,
  input  wire logic                   debug_entry,
  input  wire logic                   entry_watchpoint,
  output logic                        break_to_core,
  output logic                        system_speed_req,
  // debug register access
  input  wire logic [`TSC_DATA_W-1:0] dreg_rdata,
  output logic      [`TSC_ADDR_W-1:0] dreg_addr,
  output logic      [`TSC_DATA_W-1:0] dreg_wdata,
  output logic                        dreg_write,
  output logic                        dreg_read,
  // status
  output logic      [`TSC_IR_W-1:0]   active_instruction,
  output logic      [`TSC_CS_W-1:0]   active_chain,
  output logic                        scan_test_mode
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  tsc_pkg::tsc_core_s st_reg;
  tsc_pkg::tsc_core_s st_next;

  logic                   tap_rst;
  logic                   ir_cap;
  logic                   ir_shift;
  logic                   ir_upd;
  logic [`TSC_IR_W-1:0]   ir_shf;
  logic [`TSC_IR_W-1:0]   ir_par;

  logic                   sel_cs;
  logic                   sel_test;
  logic                   sel_c1;
  logic                   sel_c2;
  logic                   dr_cap;
  logic                   dr_shift;
  logic                   dr_upd;

  logic [`TSC_CS_W-1:0]   cs_shf;
  logic [`TSC_CS_W-1:0]   cs_par;

  logic [`TSC_C1_W-1:0]   c1_cap;
  logic [`TSC_C1_W-1:0]   c1_shf;
  logic [`TSC_C1_W-1:0]   c1_par;
  logic [`TSC_DATA_W-1:0] c1_par_data;
  logic [`TSC_DATA_W-1:0] c1_shf_data;
  logic                   c1_break_cap;

  logic [`TSC_C2_W-1:0]   c2_cap;
  logic [`TSC_C2_W-1:0]   c2_shf;
  logic                   chain_rsv;

  // ----------------------------------------------------------------
  // strobes from the test state
  // ----------------------------------------------------------------
  // test reset or the reset state returns the port to its idle setup
  assign tap_rst = srst | ~test_reset_n
                 | (tap_state == tsc_pkg::TSC_TLR);

  // each of these strobes waits for an enabled edge
  assign ir_cap   = test_clock_enable
                  & (tap_state == tsc_pkg::TSC_CAPTURE_IR);
  assign ir_shift = test_clock_enable
                  & (tap_state == tsc_pkg::TSC_SHIFT_IR);
  assign ir_upd   = test_clock_enable
                  & (tap_state == tsc_pkg::TSC_UPDATE_IR);
  assign dr_cap   = test_clock_enable
                  & (tap_state == tsc_pkg::TSC_CAPTURE_DR);
  assign dr_shift = test_clock_enable
                  & (tap_state == tsc_pkg::TSC_SHIFT_DR);
  assign dr_upd   = test_clock_enable
                  & (tap_state == tsc_pkg::TSC_UPDATE_DR);

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  tsc_scan_seg #(
    .W   (`TSC_IR_W),
    .RST (`TSC_INS_IDCODE)
  ) u_ir (
    .clk         (clk),
    .srst        (tap_rst),
    .capture_en  (ir_cap),
    .shift_en    (ir_shift),
    .update_en   (ir_upd),
    .serial_in   (test_data_in),
    .capture_val (`TSC_IR_CAPTURE),
    .shift_q     (ir_shf),
    .par_q       (ir_par)
  );

  // ----------------------------------------------------------------
  // data register selection
  // ----------------------------------------------------------------
  // cell control depends only on the active instruction, the active chain and state
  assign sel_cs   = (ir_par == `TSC_INS_CHAIN_SEL);
  assign sel_test = (ir_par == `TSC_INS_INTEST);
  assign sel_c1   = sel_test & (cs_par == `TSC_CHAIN_CORE);
  assign sel_c2   = sel_test & (cs_par == `TSC_CHAIN_DREG);

  // anything but user, core and register chains scans out zeros
  assign chain_rsv = (cs_par != `TSC_CHAIN_USER)
                   & (cs_par != `TSC_CHAIN_CORE)
                   & (cs_par != `TSC_CHAIN_DREG);

  // ----------------------------------------------------------------
  // chain select register
  // ----------------------------------------------------------------
  tsc_scan_seg #(
    .W   (`TSC_CS_W),
    .RST (`TSC_CS_RESET)
  ) u_cs (
    .clk         (clk),
    .srst        (tap_rst),
    .capture_en  (dr_cap & sel_cs),
    .shift_en    (dr_shift & sel_cs),
    .update_en   (dr_upd & sel_cs),
    .serial_in   (test_data_in),
    .capture_val (`TSC_CS_CAPTURE),
    .shift_q     (cs_shf),
    .par_q       (cs_par)
  );

  // ----------------------------------------------------------------
  // chain 1: data cells then the break cell
  // ----------------------------------------------------------------
  // data bit 0 sits next to test data in, break cell next to the output
  genvar g;
  generate
    for (g = 0; g < `TSC_DATA_W; g++)
    begin : g_c1_map
      assign c1_cap[g+1]                = core_data_out[`TSC_DATA_W-1-g];
      assign c1_par_data[`TSC_DATA_W-1-g] = c1_par[g+1];
      assign c1_shf_data[`TSC_DATA_W-1-g] = c1_shf[g+1];
    end
  endgenerate

  // a pending debug entry reports its cause once, else the pin
  assign c1_break_cap = st_reg.cause_pending ? st_reg.cause_watch
                      : external_break_input;
  assign c1_cap[`TSC_C1_BREAK_BIT] = c1_break_cap;

  tsc_scan_seg #(
    .W   (`TSC_C1_W),
    .RST ('0)
  ) u_c1 (
    .clk         (clk),
    .srst        (tap_rst),
    .capture_en  (dr_cap & sel_c1),
    .shift_en    (dr_shift & sel_c1),
    .update_en   (dr_upd & sel_c1),
    .serial_in   (test_data_in),
    .capture_val (c1_cap),
    .shift_q     (c1_shf),
    .par_q       (c1_par)
  );

  // ----------------------------------------------------------------
  // chain 2: debug register access
  // ----------------------------------------------------------------
  // no capture-dr action; the load port only returns read data
  assign c2_cap = {c2_shf[`TSC_C2_RW_BIT:`TSC_C2_ADDR_LSB], dreg_rdata};

  tsc_scan_seg #(
    .W   (`TSC_C2_W),
    .RST ('0)
  ) u_c2 (
    .clk         (clk),
    .srst        (tap_rst),
    .capture_en  (st_reg.rd_pending),
    .shift_en    (dr_shift & sel_c2),
    .update_en   (1'b0),
    .serial_in   (test_data_in),
    .capture_val (c2_cap),
    .shift_q     (c2_shf),
    .par_q       ()
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;

    // serial output follows the selected path
    st_next.tdo = 1'b0;
    if (tap_state == tsc_pkg::TSC_SHIFT_IR)
    begin
      st_next.tdo = ir_shf[0];
    end
    else if (tap_state == tsc_pkg::TSC_SHIFT_DR)
    begin
      if (sel_cs)
      begin
        st_next.tdo = cs_shf[0];
      end
      else if (sel_test)
      begin
        if (chain_rsv)
        begin
          st_next.tdo = 1'b0;
        end
        else if (sel_c1)
        begin
          st_next.tdo = c1_shf[0];
        end
        else if (sel_c2)
        begin
          st_next.tdo = c2_shf[0];
        end
        else
        begin
          st_next.tdo = user_chain_tdo;
        end
      end
      else
      begin
        st_next.tdo = other_tdo;
      end
    end

    // test mode flag under internal test; chain 1 cells switch only with chain 1 active
    st_next.test_mode = sel_test;

    // input cells: core sees the update stage with chain 1 in test
    st_next.core_data_in = sel_c1 ? c1_par_data : sys_data_in;
    st_next.break_to_core = sel_c1 ? c1_par[`TSC_C1_BREAK_BIT]
                          : external_break_input;

    // output cells: system sees the serial stage with chain 1 in test
    st_next.sys_data_out = sel_c1 ? c1_shf_data : core_data_out;

    // break cell loaded with an instruction asks for system speed
    st_next.speed_req = in_debug & c1_par[`TSC_C1_BREAK_BIT];

    // entry cause held until the first break cell capture
    if (dr_cap & sel_c1)
    begin
      st_next.cause_pending = 1'b0;
    end
    if (debug_entry)
    begin
      st_next.cause_pending = 1'b1;
      st_next.cause_watch   = entry_watchpoint;
    end

    // debug register strobes last one cycle
    st_next.dreg_write = 1'b0;
    st_next.dreg_read  = 1'b0;
    st_next.rd_pending = 1'b0;
    if (dr_upd & sel_c2)
    begin
      st_next.dreg_addr =
        c2_shf[`TSC_C2_ADDR_MSB:`TSC_C2_ADDR_LSB];
      if (c2_shf[`TSC_C2_RW_BIT])
      begin
        st_next.dreg_wdata = c2_shf[`TSC_C2_DATA_MSB:0];
        st_next.dreg_write = 1'b1;
      end
      else
      begin
        st_next.dreg_read  = 1'b1;
        st_next.rd_pending = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign test_data_out      = st_reg.tdo;
  assign core_data_in       = st_reg.core_data_in;
  assign sys_data_out       = st_reg.sys_data_out;
  assign break_to_core      = st_reg.break_to_core;
  assign system_speed_req   = st_reg.speed_req;
  assign dreg_addr          = st_reg.dreg_addr;
  assign dreg_wdata         = st_reg.dreg_wdata;
  assign dreg_write         = st_reg.dreg_write;
  assign dreg_read          = st_reg.dreg_read;
  assign active_instruction = ir_par;
  assign active_chain       = cs_par;
  assign scan_test_mode     = st_reg.test_mode;

endmodule

// ### tb/tsc_chain_regs_properties.sv
`timescale 1ns/1ps
`include "tsc_consts.svh"

module tsc_chain_regs_properties (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   srst,
  // serial port
  input wire logic                   test_reset_n,
  input wire logic                   test_clock_enable,
  input wire tsc_pkg::tsc_tap_e      tap_state,
  input wire logic                   test_data_out,
  // data cells
  input wire logic [`TSC_DATA_W-1:0] sys_data_in,
  input wire logic [`TSC_DATA_W-1:0] core_data_out,
  input wire logic [`TSC_DATA_W-1:0] core_data_in,
  input wire logic [`TSC_DATA_W-1:0] sys_data_out,
  // debug side
  input wire logic                   in_debug,
  input wire logic                   system_speed_req,
  input wire logic                   dreg_write,
  input wire logic                   dreg_read,
  // status
  input wire logic [`TSC_IR_W-1:0]   active_instruction,
  input wire logic [`TSC_CS_W-1:0]   active_chain,
  input wire logic                   scan_test_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  logic en;
  logic rst_any;
  logic upd_dreg;
  logic intest;
  assign en = test_clock_enable;
  assign intest = active_instruction == `TSC_INS_INTEST;
  assign rst_any = !test_reset_n || tap_state == tsc_pkg::TSC_TLR;
  assign upd_dreg = en && test_reset_n && intest
    && tap_state == tsc_pkg::TSC_UPDATE_DR && active_chain == `TSC_CHAIN_DREG;

  sequence cap_ir_s;
    en && !rst_any && tap_state == tsc_pkg::TSC_CAPTURE_IR
    ##1 en && test_reset_n && tap_state == tsc_pkg::TSC_SHIFT_IR;
  endsequence
  sequence cap_cs_s;
    en && test_reset_n && tap_state == tsc_pkg::TSC_CAPTURE_DR
    && active_instruction == `TSC_INS_CHAIN_SEL;
  endsequence
  sequence sh_dr_s;
    en && test_reset_n && tap_state == tsc_pkg::TSC_SHIFT_DR;
  endsequence

  chk_ir_capture: assert property (cap_ir_s |=> test_data_out)
    else $error("ir capture bit not first out");
  chk_cs_first: assert property (cap_cs_s ##1 sh_dr_s |=> !test_data_out)
    else $error("chain select bit 0 not zero");
  chk_cs_last: assert property (cap_cs_s ##1 sh_dr_s [*4] |=> test_data_out)
    else $error("chain select bit 3 not one");
  chk_ir_hold: assert property (!$stable(active_instruction) |->
    $past(srst || rst_any || en && tap_state == tsc_pkg::TSC_UPDATE_IR))
    else $error("instruction changed without update");
  chk_chain_hold: assert property (!$stable(active_chain) |->
    $past(srst || rst_any || en && tap_state == tsc_pkg::TSC_UPDATE_DR
    && active_instruction == `TSC_INS_CHAIN_SEL))
    else $error("chain changed without select update");
  chk_trst_sel: assert property (!test_reset_n |=>
    active_instruction == `TSC_INS_IDCODE && active_chain == `TSC_CHAIN_USER)
    else $error("test reset selection wrong");
  chk_rsv_zero: assert property (intest &&
    tap_state == tsc_pkg::TSC_SHIFT_DR && !(active_chain inside {4'h0,
    4'h1, 4'h2}) |=> !test_data_out)
    else $error("reserved chain shifted a one");
  chk_dreg_pulse: assert property (upd_dreg |=> dreg_write != dreg_read)
    else $error("no single access after update");
  chk_dreg_cause: assert property (dreg_write || dreg_read |->
    $past(upd_dreg))
    else $error("access without chain 2 update");
  chk_mode_follow: assert property (
    scan_test_mode == $past(intest))
    else $error("test mode not following instruction");
  chk_core_pass: assert property (!$past(srst) && !$past(scan_test_mode)
    && !$past(intest) |-> core_data_in == $past(sys_data_in))
    else $error("core input not passed through");
  chk_sys_pass: assert property (!$past(srst) && !$past(scan_test_mode)
    && !$past(intest) |-> sys_data_out == $past(core_data_out))
    else $error("system output not passed through");
  chk_speed_req: assert property (system_speed_req |-> $past(in_debug))
    else $error("speed request outside debug");
endmodule

bind tsc_chain_regs tsc_chain_regs_properties tsc_chain_regs_properties_i (
  .clk(clk), .srst(srst), .test_reset_n(test_reset_n),
  .test_clock_enable(test_clock_enable), .tap_state(tap_state),
  .test_data_out(test_data_out), .sys_data_in(sys_data_in),
  .core_data_out(core_data_out), .core_data_in(core_data_in),
  .sys_data_out(sys_data_out), .in_debug(in_debug),
  .system_speed_req(system_speed_req), .dreg_write(dreg_write),
  .dreg_read(dreg_read), .active_instruction(active_instruction),
  .active_chain(active_chain), .scan_test_mode(scan_test_mode));

// ### tb/tsc_ctl_model.sv
`timescale 1ns/1ps

module tsc_ctl_model (
  // clock
  input  wire logic         clk,
  // serial test port
  input  wire logic         test_data_out,
  output tsc_pkg::tsc_tap_e tap_state,
  output logic              test_clock_enable,
  output logic              test_data_in
);
  initial
  begin
    tap_state = tsc_pkg::TSC_IDLE;
    test_clock_enable = 1'b0;
    test_data_in = 1'b0;
  end

  // capture, n shifts, update; slow adds a disabled edge before each bit
  task automatic scan(input tsc_pkg::tsc_tap_e cap, sh, upd, input int n,
    input logic [37:0] din, input logic slow, output logic [37:0] dout);
    dout = '0;
    @(posedge clk);
    tap_state <= cap;
    test_clock_enable <= 1'b1;
    for (int i = 0; i <= n; i++)
    begin
      @(posedge clk);
      // tdo shows a bit one edge after the enabled shift edge of that bit
      if (slow)
      begin
        test_clock_enable <= 1'b0;
        @(posedge clk);
        test_clock_enable <= 1'b1;
        if (i > 0)
          dout[i-1] = test_data_out;
      end
      else if (i > 1)
        dout[i-2] = test_data_out;
      tap_state <= (i < n) ? sh : upd;
      test_data_in <= (i < n) ? din[i] : ~test_data_in;
    end
    @(posedge clk);
    if (!slow)
      dout[n-1] = test_data_out;
    tap_state <= tsc_pkg::TSC_IDLE;
    test_clock_enable <= 1'b0;
    // let the update reach the outputs before the caller looks
    @(posedge clk);
  endtask
endmodule

// ### tb/tsc_chain_regs_tb.sv
`timescale 1ns/1ps
`include "tsc_consts.svh"

module tsc_chain_regs_tb;
  logic              clk, srst, test_reset_n, other_tdo, user_chain_tdo;
  logic              external_break_input, in_debug, debug_entry;
  logic              entry_watchpoint, test_data_out, test_data_in;
  logic              test_clock_enable, break_to_core, system_speed_req;
  logic              dreg_write, dreg_read, scan_test_mode;
  logic [31:0]       core_data_out, sys_data_in, dreg_rdata, dat;
  logic [31:0]       core_data_in, sys_data_out, dreg_wdata, seen_data;
  logic [4:0]        dreg_addr, seen_addr;
  logic [3:0]        active_instruction, active_chain;
  logic [1:0]        seen;
  logic [37:0]       d, c1;
  logic [3:0]        chains [6];
  logic [7:0]        exp_out [6];
  tsc_pkg::tsc_tap_e tap_state;
  int                err_count, checks_done;

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  tsc_chain_regs tsc_chain_regs_i (.clk(clk), .srst(srst),
    .test_reset_n(test_reset_n), .test_clock_enable(test_clock_enable),
    .tap_state(tap_state), .test_data_in(test_data_in),
    .test_data_out(test_data_out), .other_tdo(other_tdo),
    .user_chain_tdo(user_chain_tdo), .core_data_out(core_data_out),
    .sys_data_in(sys_data_in), .core_data_in(core_data_in),
    .sys_data_out(sys_data_out), .external_break_input(external_break_input),
    .in_debug(in_debug), .debug_entry(debug_entry),
    .entry_watchpoint(entry_watchpoint), .break_to_core(break_to_core),
    .system_speed_req(system_speed_req), .dreg_rdata(dreg_rdata),
    .dreg_addr(dreg_addr), .dreg_wdata(dreg_wdata), .dreg_write(dreg_write),
    .dreg_read(dreg_read), .active_instruction(active_instruction),
    .active_chain(active_chain), .scan_test_mode(scan_test_mode));

  tsc_ctl_model tsc_ctl_model_i (.clk(clk), .test_data_out(test_data_out),
    .tap_state(tap_state), .test_clock_enable(test_clock_enable),
    .test_data_in(test_data_in));

  // remembers the last debug register access
  always @(posedge clk)
    if (dreg_write || dreg_read)
    begin
      seen <= {dreg_write, dreg_read};
      seen_addr <= dreg_addr;
      seen_data <= dreg_wdata;
    end

  task automatic cmp_v(input logic [37:0] got, input logic [37:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic ir(input logic [3:0] code);
    tsc_ctl_model_i.scan(tsc_pkg::TSC_CAPTURE_IR, tsc_pkg::TSC_SHIFT_IR,
      tsc_pkg::TSC_UPDATE_IR, 4, 38'(code), 1'b0, d);
  endtask

  task automatic dr(input int n, input logic [37:0] din, input logic slow);
    tsc_ctl_model_i.scan(tsc_pkg::TSC_CAPTURE_DR, tsc_pkg::TSC_SHIFT_DR,
      tsc_pkg::TSC_UPDATE_DR, n, din, slow, d);
  endtask

  // select a chain, then enter internal test on it
  task automatic pick(input logic [3:0] chain);
    ir(`TSC_INS_CHAIN_SEL);
    dr(4, 38'(chain), 1'b0);
    ir(`TSC_INS_INTEST);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    srst = 1'b1;
    test_reset_n = 1'b1;
    other_tdo = 1'b1;
    user_chain_tdo = 1'b1;
    external_break_input = 1'b0;
    in_debug = 1'b0;
    debug_entry = 1'b0;
    entry_watchpoint = 1'b0;
    core_data_out = 32'h3C5A_96E1;
    sys_data_in = 32'h0F1E_2D3C;
    dreg_rdata = 32'h6B2D_F047;
    dat = 32'hC3A5_0F96;
    seen = 2'h0;
    seen_addr = 5'h00;
    seen_data = 32'h0;
    d = 38'h0;
    c1 = 38'h1;
    for (int k = 0; k < 32; k++)
      c1[32-k] = dat[k];
    chains = '{4'h0, 4'h3, 4'h4, 4'h8, 4'h5, 4'hF};
    exp_out = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    err_count = 0;
    checks_done = 0;
    tick(6);
    srst <= 1'b0;
    tick(1);
    cmp_v(38'(active_instruction), 38'(`TSC_INS_IDCODE));
    ir(`TSC_INS_CHAIN_SEL);
    cmp_v(d, 38'(`TSC_IR_CAPTURE));
    cmp_v(38'(active_instruction), 38'(`TSC_INS_CHAIN_SEL));
    dr(4, 38'(`TSC_CHAIN_CORE), 1'b1);
    cmp_v(38'(active_chain), 38'(`TSC_CHAIN_CORE));
    dr(4, 38'(`TSC_CHAIN_DREG), 1'b0);
    cmp_v(d, 38'(`TSC_CS_CAPTURE));
    cmp_v(38'(active_chain), 38'(`TSC_CHAIN_DREG));
    $display("test select done");
    ir(`TSC_INS_INTEST);
    dr(38, {1'b1, 5'h15, 32'hA5C3_1E70}, 1'b0);
    tick(3);
    cmp_v({seen[1], seen_addr, seen_data}, {1'b1, 5'h15, 32'hA5C3_1E70});
    dr(38, {1'b0, 5'h0B, 32'h0}, 1'b0);
    tick(3);
    cmp_v({seen[0], seen_addr, 32'h0}, {1'b1, 5'h0B, 32'h0});
    dr(38, 38'h0, 1'b0);
    cmp_v(d, {1'b0, 5'h0B, dreg_rdata});
    $display("test dreg done");
    pick(`TSC_CHAIN_CORE);
    in_debug <= 1'b1;
    debug_entry <= 1'b1;
    entry_watchpoint <= 1'b1;
    tick(1);
    debug_entry <= 1'b0;
    dr(33, c1, 1'b0);
    tick(1);
    cmp_v(38'(d[0]), 38'h1);
    cmp_v(38'(core_data_in), 38'(dat));
    cmp_v(38'(sys_data_out), 38'(dat));
    cmp_v({36'h0, system_speed_req, break_to_core}, 38'h3);
    dr(33, 38'h0, 1'b0);
    cmp_v(38'(d[0]), 38'h0);
    ir(`TSC_INS_BYPASS);
    tick(2);
    cmp_v(38'(core_data_in), 38'(sys_data_in));
    cmp_v(38'(sys_data_out), 38'(core_data_out));
    in_debug <= 1'b0;
    $display("test core chain done");
    for (int k = 0; k < 6; k++)
    begin
      pick(chains[k]);
      dr(8, 38'hFF, 1'b0);
      cmp_v(d, 38'(exp_out[k]));
    end
    $display("test chain decode done");
    test_reset_n <= 1'b0;
    tick(2);
    test_reset_n <= 1'b1;
    tick(1);
    cmp_v({30'h0, active_instruction, active_chain}, 38'h0E0);
    $display("test reset done");
    give_verdict();
  end
endmodule
